// >>> bhcs_params.svh
// Constants for the bus hold and chip select block.
`ifndef BHCS_PARAMS_SVH
`define BHCS_PARAMS_SVH
`define BHCS_ADDR_W 20
`define BHCS_UCS_RST_START 20'hFFC00
`define BHCS_UCS_RST_STOP 20'hFFFFF
`define BHCS_LCS_RST_START 20'h00000
`define BHCS_LCS_RST_STOP 20'h00000
`define BHCS_NUM_FAULT_VEC 8'h10
`define BHCS_GCS_N 8
`define BHCS_PORT_RST_BIT 1'b1
`endif

// >>> bhcs_pkg.sv
// Types for the bus hold and chip select block.
`include "bhcs_params.svh"
package bhcs_pkg;
  typedef enum logic [2:0] {
    BHCS_OWN = 3'h1,
    BHCS_WAIT = 3'h2,
    BHCS_RELEASED = 3'h4
  } bhcs_hold_e;
  typedef logic [`BHCS_ADDR_W-1:0] bhcs_addr_t;
endpackage : bhcs_pkg

// >>> bhcs_top.sv
// Bus direction, lock, hold handshake, numerics and chip select decode logic.
// Contract
// - Drive buffer direction: high for outward writes, low for inward reads.
// - While lock is asserted, never interrupt the cycle nor grant hold.
// - Release the bus only at an unlocked instruction boundary.
// - With release acknowledge high, data bus and bus controls are floated.
// - Assert numerics select on any access aimed at the coprocessor.
// - Fault sampled at numerics operation start raises interrupt type 16.
// - Upper select goes active for memory or I/O cycles in its range.
// - After reset upper select covers memory 0FFC00H through 0FFFFFH.
// - Lower select goes active only for memory cycles within its range.
// - Lower select stays inactive from reset until its range is programmed.
// - Each enabled generic select goes active for in-range memory or I/O cycles.
// - A generic pin not used as select drives its output port bit.
// - Software can read back the generic pin's present value.
// - A cycle ends only on ready, unless its region says ignore ready.
`timescale 1ns/1ps
`default_nettype none
module bhcs_top
  import bhcs_pkg::*;
#(
  parameter int GCS_N = `BHCS_GCS_N
) (
  input wire logic clock, // 125 MHz processor clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic cycle_start, // Pulse: a bus cycle begins.
  input wire logic cycle_is_mem, // Cycle is memory (1) or I/O (0).
  input wire logic cycle_is_write, // Cycle moves data outward.
  input wire logic cycle_is_numerics, // Cycle is aimed at the coprocessor.
  input wire bhcs_addr_t cycle_addr, // Cycle address.
  input wire logic ready, // Ready input from the addressed slave.
  output logic cycle_done, // Pulse: the current bus cycle ends.
  input wire logic insn_boundary, // Pulse: core sits at an instruction boundary.
  input wire logic lock_req, // Core requests a locked sequence.
  input wire logic lock_in, // Lock pin input level.
  output logic lock_n_o, // Lock pin drive value, active low.
  output logic lock_oe, // Lock pin drive enable.
  input wire logic hold, // Bus takeover request.
  output logic bus_release_ack, // Bus released to the other master.
  output logic bus_float, // Float data bus and bus controls.
  output logic buffer_direction, // 1 transmit, 0 receive.
  output logic numerics_select_n, // Coprocessor select, active low.
  input wire logic numerics_fault_n, // Coprocessor fault, active low.
  input wire logic numerics_op_start, // Pulse: a numerics operation begins.
  input wire logic numerics_transfer_req, // Coprocessor transfer pending.
  output logic numerics_xfer_pending, // Transfer request seen by the core.
  output logic fault_irq, // Pulse: raise interrupt.
  output logic [7:0] fault_irq_type, // Interrupt type with fault_irq.
  input wire logic cfg_we, // Pulse: load region configuration.
  input wire logic [3:0] cfg_sel, // 0 upper, 1 lower, 2+n generic n.
  input wire bhcs_addr_t cfg_start, // Range start address.
  input wire bhcs_addr_t cfg_stop, // Range stop address, inclusive.
  input wire logic cfg_mem, // Region responds to memory cycles.
  input wire logic cfg_io, // Region responds to I/O cycles.
  input wire logic cfg_en, // Region enabled as a select.
  input wire logic cfg_ign_ready, // Region ignores ready.
  input wire logic port_we, // Pulse: load port output latch.
  input wire logic [GCS_N-1:0] port_wdata, // Port latch data.
  output logic [GCS_N-1:0] port_rdata, // Read-back of generic pin values.
  output logic upper_region_select_n, // Upper select, active low.
  output logic lower_region_select_n, // Lower select, active low.
  output logic [GCS_N-1:0] generic_region_select_n // Generic select or port, pins.
);

  localparam int NR = GCS_N + 2;

  typedef struct packed {
    bhcs_hold_e hold_st;
    logic locked;
    logic in_cycle;
    logic dir;
    logic ncs_n;
    logic ign_ready;
    logic irq;
    logic xreq;
    logic [NR-1:0] act;
    logic [NR-1:0] en;
    logic [NR-1:0] mem;
    logic [NR-1:0] io;
    logic [NR-1:0] ign;
    logic [NR-1:0][`BHCS_ADDR_W-1:0] start;
    logic [NR-1:0][`BHCS_ADDR_W-1:0] stop;
    logic [GCS_N-1:0] port;
  } bhcs_state_s;

  bhcs_state_s st_r;
  bhcs_state_s st_nxt;

  // ----------------------------------------------------------------
  // Range match helper
  // ----------------------------------------------------------------
  // Tells whether an address falls in an inclusive range.
  function automatic logic bhcs_in_range(input bhcs_addr_t a, input bhcs_addr_t lo,
                                         input bhcs_addr_t hi);
    bhcs_in_range = (a >= lo) && (a <= hi);
  endfunction : bhcs_in_range

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Builds the next state from cycles, hold, lock and configuration.
  always_comb begin
    logic hit;
    logic done;
    hit = 1'b0;
    done = 1'b0;
    st_nxt = st_r;
    st_nxt.irq = 1'b0;
    st_nxt.xreq = numerics_transfer_req;
    // Lock follows the core's request while the bus is ours, also while a takeover waits.
    // Freezing it during the wait would keep a stale lock and block the release forever.
    if (st_r.hold_st != BHCS_RELEASED) begin
      st_nxt.locked = lock_req;
    end
    // Cycle end waits for ready unless the region ignores it.
    done = st_r.in_cycle && (ready || st_r.ign_ready);
    if (done) begin
      st_nxt.in_cycle = 1'b0;
      st_nxt.act = '0;
      st_nxt.ncs_n = 1'b1;
      st_nxt.dir = 1'b0;
    end
    // Start a new cycle and decode every region.
    if (cycle_start && st_r.hold_st == BHCS_OWN && !st_nxt.in_cycle) begin
      st_nxt.in_cycle = 1'b1;
      st_nxt.dir = cycle_is_write;
      st_nxt.ncs_n = !cycle_is_numerics;
      st_nxt.ign_ready = 1'b0;
      for (int i = 0; i < NR; i++) begin
        hit = st_r.en[i] && bhcs_in_range(cycle_addr, st_r.start[i], st_r.stop[i])
              && (cycle_is_mem ? st_r.mem[i] : st_r.io[i]);
        st_nxt.act[i] = hit;
        if (hit && st_r.ign[i]) begin
          st_nxt.ign_ready = 1'b1;
        end
      end
    end
    // Fault sampled at a numerics operation start raises the interrupt.
    if (numerics_op_start && !numerics_fault_n) begin
      st_nxt.irq = 1'b1;
    end
    // Hold handshake: release only between unlocked instructions.
    case (st_r.hold_st)
      BHCS_OWN: begin
        if (hold) begin
          st_nxt.hold_st = BHCS_WAIT;
        end
      end
      BHCS_WAIT: begin
        if (!hold) begin
          st_nxt.hold_st = BHCS_OWN;
        end else if (insn_boundary && !st_r.locked && !lock_req &&
                     !st_r.in_cycle) begin
          st_nxt.hold_st = BHCS_RELEASED;
        end
      end
      BHCS_RELEASED: begin
        if (!hold) begin
          st_nxt.hold_st = BHCS_OWN;
        end
      end
      default: begin
        st_nxt.hold_st = BHCS_OWN;
      end
    endcase
    // Region configuration; lower region stays off until written.
    if (cfg_we && 32'(cfg_sel) < NR) begin
      st_nxt.start[cfg_sel] = cfg_start;
      st_nxt.stop[cfg_sel] = cfg_stop;
      st_nxt.en[cfg_sel] = cfg_en;
      st_nxt.mem[cfg_sel] = cfg_mem;
      st_nxt.io[cfg_sel] = (cfg_sel == 4'h1) ? 1'b0 : cfg_io;
      st_nxt.ign[cfg_sel] = cfg_ign_ready;
    end
    if (port_we) begin
      st_nxt.port = port_wdata;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Registers the state; upper region covers the top 1K of memory at reset.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.hold_st <= BHCS_OWN;
      st_r.ncs_n <= 1'b1;
      st_r.port <= {GCS_N{`BHCS_PORT_RST_BIT}};
      st_r.en[0] <= 1'b1;
      st_r.mem[0] <= 1'b1;
      st_r.start[0] <= `BHCS_UCS_RST_START;
      st_r.stop[0] <= `BHCS_UCS_RST_STOP;
      st_r.start[1] <= `BHCS_LCS_RST_START;
      st_r.stop[1] <= `BHCS_LCS_RST_STOP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pin values from registers, cycle_done also from ready; lock pin is released during reset.
  assign lock_n_o = !st_r.locked;
  assign lock_oe = resetn && !bus_float;
  assign bus_release_ack = (st_r.hold_st == BHCS_RELEASED);
  assign bus_float = bus_release_ack;
  assign buffer_direction = st_r.dir;
  assign numerics_select_n = st_r.ncs_n;
  assign numerics_xfer_pending = st_r.xreq;
  assign fault_irq = st_r.irq;
  assign fault_irq_type = `BHCS_NUM_FAULT_VEC;
  assign cycle_done = st_r.in_cycle && (ready || st_r.ign_ready);
  assign upper_region_select_n = !st_r.act[0];
  assign lower_region_select_n = !st_r.act[1];

  // Generic pins carry the select when enabled, else the port latch.
  always_comb begin
    for (int g = 0; g < GCS_N; g++) begin
      generic_region_select_n[g] = st_r.en[g+2] ? !st_r.act[g+2] : st_r.port[g];
    end
  end
  assign port_rdata = generic_region_select_n;

  logic unused_lock_in;
  assign unused_lock_in = lock_in;

endmodule : bhcs_top
`default_nettype wire

// >>> bhcs_partner.sv
// Far-side model: takeover master, coprocessor and wait-state memory.
`timescale 1ns/1ps
`default_nettype none
module bhcs_partner (
  input wire logic clock, // Clock.
  input wire logic resetn, // Reset.
  input wire logic cycle_start, // Cycle start.
  input wire logic bus_release_ack, // Release ack.
  input wire logic want_bus, // Bench asks.
  input wire logic want_xfer, // Bench asks.
  input wire logic [1:0] wait_states, // Waits.
  output logic hold, // Takeover.
  output logic ready, // Ready.
  output logic numerics_transfer_req // Pending.
);
  logic [1:0] cnt_r;
  // Ready is held off for the wait states of each cycle.
  assign ready = cnt_r == 2'h0;
  // Hold stays up until acknowledged; counter runs per cycle.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {hold, numerics_transfer_req, cnt_r} <= 4'h0;
    end else begin
      hold <= want_bus | (hold & ~bus_release_ack);
      numerics_transfer_req <= want_xfer;
      cnt_r <= cycle_start ? wait_states : cnt_r - {1'b0, ~ready};
    end
  end
endmodule : bhcs_partner
`default_nettype wire

// >>> bhcs_top_chk.sv
// Port assertions for the bus hold and chip select block.
`timescale 1ns/1ps
`default_nettype none
module bhcs_top_chk (
  input wire logic clock, // Clock.
  input wire logic resetn, // Reset, active low.
  input wire logic cycle_start, // Cycle start pulse.
  input wire logic cycle_is_mem, // Memory cycle.
  input wire logic cycle_is_write, // Write cycle.
  input wire logic cycle_is_numerics, // Coprocessor cycle.
  input wire logic insn_boundary, // Instruction boundary.
  input wire logic lock_n_o, // Lock pin value.
  input wire logic lock_oe, // Lock pin enable.
  input wire logic hold, // Takeover request.
  input wire logic bus_release_ack, // Release acknowledge.
  input wire logic bus_float, // Bus floated.
  input wire logic buffer_direction, // Buffer direction.
  input wire logic numerics_select_n, // Coprocessor select.
  input wire logic lower_region_select_n, // Lower select.
  input wire logic numerics_fault_n, // Coprocessor fault.
  input wire logic numerics_op_start, // Numerics operation start.
  input wire logic fault_irq, // Fault interrupt.
  input wire logic [7:0] fault_irq_type // Interrupt type.
);
  // One clock domain; checks pause in reset.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_grant; $rose(bus_release_ack); endsequence
  sequence s_drop; bus_release_ack && !hold; endsequence
  property p_dir; $rose(buffer_direction) |-> $past(cycle_is_write); endproperty
  a_dir: assert property (p_dir) else $error("bad direction");
  property p_lock; s_grant |-> $past(lock_n_o); endproperty
  a_lock: assert property (p_lock) else $error("grant in lock");
  property p_bnd; s_grant |-> $past(insn_boundary) || $past(insn_boundary, 2); endproperty
  a_bnd: assert property (p_bnd) else $error("grant off boundary");
  property p_flt; bus_release_ack |-> bus_float && !lock_oe; endproperty
  a_flt: assert property (p_flt) else $error("not floated");
  property p_rel; s_drop |-> ##[1:2] !bus_release_ack; endproperty
  a_rel: assert property (p_rel) else $error("ack stuck");
  property p_ncs; $fell(numerics_select_n) |-> $past(cycle_is_numerics); endproperty
  a_ncs: assert property (p_ncs) else $error("bad select");
  property p_irq; numerics_op_start && !numerics_fault_n |=> fault_irq && fault_irq_type == 8'h10;
  endproperty
  a_irq: assert property (p_irq) else $error("no fault irq");
  property p_low; $fell(lower_region_select_n) |-> $past(cycle_is_mem); endproperty
  a_low: assert property (p_low) else $error("lower on io");
endmodule : bhcs_top_chk
bind bhcs_top bhcs_top_chk bhcs_top_chk_i (.*);
`default_nettype wire

// >>> tb_bus_hold_and_chip_select.sv
// Self-checking bench for the bus hold and chip select block.
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_bus_hold_and_chip_select;
  import bhcs_pkg::*;
  logic clock, resetn, cycle_start, cycle_is_mem, cycle_is_write, cycle_is_numerics, ready;
  logic cycle_done, insn_boundary, lock_req, lock_in, lock_n_o, lock_oe, hold, bus_float;
  logic bus_release_ack, buffer_direction, numerics_select_n, numerics_fault_n, fault_irq;
  logic numerics_op_start, numerics_transfer_req, numerics_xfer_pending, cfg_we, cfg_mem;
  logic cfg_io, cfg_en, cfg_ign_ready, port_we, want_bus, want_xfer, upper_region_select_n;
  logic lower_region_select_n;
  logic [7:0] fault_irq_type, port_wdata, port_rdata, generic_region_select_n, g;
  logic [3:0] cfg_sel, sl;
  logic [1:0] wait_states;
  bhcs_addr_t cycle_addr, cfg_start, cfg_stop;
  int err_count, compares, k;
  bhcs_top bhcs_top_i (.*);
  bhcs_partner bhcs_partner_i (.*);
  // Clock of 8 ns period.
  always #4 clock = ~clock;
  // Prints counts and verdict, then stops.
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // One clock step; inputs move just after the edge.
  task automatic tk;
    @(posedge clock) #1;
  endtask : tk
  // Runs one bus cycle; checks selects and the ready wait.
  task automatic cyc(input logic [2:0] f, input bhcs_addr_t a, input logic [1:0] ws,
                     input logic [3:0] e, ek);
    {cycle_is_mem, cycle_is_write, cycle_is_numerics, cycle_addr, wait_states} = {f, a, ws};
    cycle_start = 1'b1;
    tk;
    cycle_start = 1'b0;
    for (k = 0; k < 9 && cycle_done !== 1'b1; k++) tk;
    g = generic_region_select_n;
    sl = {upper_region_select_n, lower_region_select_n, numerics_select_n, buffer_direction};
    `CK({sl, k[3:0]}, {e, ek})
    tk;
  endtask : cyc
  // Loads one region's range and flags.
  task automatic cfg(input logic [3:0] s, input bhcs_addr_t lo, hi, input logic [2:0] f);
    {cfg_sel, cfg_start, cfg_stop, cfg_mem, cfg_io, cfg_ign_ready} = {s, lo, hi, f};
    {cfg_en, cfg_we} = 2'b11;
    tk;
    cfg_we = 1'b0;
    tk;
  endtask : cfg
  // Upper and lower regions: reset state, range edges, memory against I/O.
  task automatic t_regions;
    `CK({upper_region_select_n, lower_region_select_n, numerics_select_n}, 3'h7)
    cyc(3'h6, 20'hFFC00, 2'h2, 4'h7, 4'h2);
    cyc(3'h4, 20'hFFBFF, 2'h0, 4'hE, 4'h0);
    cyc(3'h0, 20'hFFFFF, 2'h1, 4'hE, 4'h1);
    cyc(3'h4, 20'h00000, 2'h0, 4'hE, 4'h0);
    cfg(4'h1, 20'h00000, 20'h003FF, 3'h6);
    cyc(3'h0, 20'h00100, 2'h0, 4'hE, 4'h0);
    cyc(3'h4, 20'h003FF, 2'h0, 4'hA, 4'h0);
    cfg(4'h0, 20'h10000, 20'h1FFFF, 3'h6);
    cyc(3'h0, 20'h1FFFF, 2'h1, 4'h6, 4'h1);
    $display("t_regions ended");
  endtask : t_regions
  // Generic pin as port bit, then as an I/O select that ignores ready.
  task automatic t_gen;
    {port_wdata, port_we} = {8'hA5, 1'b1};
    tk;
    port_we = 1'b0;
    tk;
    `CK({generic_region_select_n, port_rdata}, 16'hA5A5)
    cfg(4'h5, 20'h02000, 20'h02FFF, 3'h3);
    `CK(port_rdata, 8'hAD)
    cyc(3'h0, 20'h02000, 2'h3, 4'hE, 4'h0);
    `CK(g, 8'hA5)
    cyc(3'h4, 20'h02FFF, 2'h0, 4'hE, 4'h0);
    `CK(g, 8'hAD)
    $display("t_gen ended");
  endtask : t_gen
  // Coprocessor select, fault interrupt and transfer request.
  task automatic t_num;
    cyc(3'h5, 20'h80000, 2'h0, 4'hC, 4'h0);
    {numerics_fault_n, numerics_op_start, want_xfer} = 3'b011;
    tk;
    `CK({fault_irq, fault_irq_type}, 9'h110)
    numerics_fault_n = 1'b1;
    tk;
    `CK({fault_irq, numerics_xfer_pending}, 2'b01)
    {numerics_op_start, want_xfer} = 2'b00;
    $display("t_num ended");
  endtask : t_num
  // Takeover refused under lock, granted at an unlocked boundary.
  task automatic t_hold;
    {lock_req, want_bus, insn_boundary} = 3'b111;
    tk;
    insn_boundary = 1'b0;
    repeat (3) tk;
    `CK({bus_release_ack, lock_n_o}, 2'b00)
    {lock_req, want_bus} = 2'b00;
    repeat (3) tk;
    `CK({bus_release_ack, lock_n_o, hold}, 3'b011)
    insn_boundary = 1'b1;
    tk;
    insn_boundary = 1'b0;
    for (k = 0; k < 4 && bus_release_ack !== 1'b1; k++) tk;
    `CK({bus_release_ack, bus_float, lock_oe}, 3'b110)
    want_bus = 1'b1;
    cyc(3'h4, 20'h10000, 2'h0, 4'hE, 4'h9);
    want_bus = 1'b0;
    repeat (3) tk;
    `CK({bus_release_ack, hold}, 2'b00)
    $display("t_hold ended");
  endtask : t_hold
  // Reset for three cycles, then the scenarios.
  initial begin
    {clock, resetn, cycle_start, cycle_is_mem, cycle_is_write, cycle_is_numerics} = '0;
    {insn_boundary, lock_req, numerics_op_start, cfg_we, cfg_mem, cfg_io, cfg_en} = '0;
    {cfg_ign_ready, port_we, want_bus, want_xfer, cfg_sel, wait_states, port_wdata} = '0;
    {cycle_addr, cfg_start, cfg_stop, err_count, compares} = '0;
    {lock_in, numerics_fault_n} = 2'b11;
    repeat (3) tk;
    `CK({lock_oe, lock_n_o, bus_release_ack}, 3'h2)
    `CK(generic_region_select_n, 8'hFF)
    resetn = 1'b1;
    t_regions;
    t_gen;
    t_num;
    t_hold;
    tally_and_finish;
  end
  // Watchdog against a hang.
  initial begin
    #20000;
    err_count++;
    tally_and_finish;
  end
endmodule : tb_bus_hold_and_chip_select
`default_nettype wire
